/* File: hdl/foc_pkg.sv */
package foc_pkg;
  // data widths
  localparam int DW = 16;
  localparam int AW = 8;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] RATE_OFF   = 8'h04;
  localparam logic [7:0] VGAIN_OFF  = 8'h08;
  localparam logic [7:0] CGAIN_OFF  = 8'h0C;
  localparam logic [7:0] LIMIT_OFF  = 8'h10;
  localparam logic [7:0] TARGET_OFF = 8'h14;
  localparam logic [7:0] RES_OFF    = 8'h18;
  localparam logic [7:0] REF_OFF    = 8'h1C;
  localparam logic [7:0] VOLT_OFF   = 8'h20;
  localparam logic [7:0] STAT_OFF   = 8'h24;
  // control field positions
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_BYPASS = 1;
  localparam int CTRL_OVMOD  = 2;
  localparam int CTRL_MEAS   = 3;
  localparam int CTRL_STOP   = 4;
  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] RATE_RST  = 32'h0010_0010;
  localparam logic [31:0] GAIN_RST  = 32'h0010_0100;
  localparam logic [31:0] LIMIT_RST = 32'h7000_4000;
  // gain fraction bits and duty fraction bits
  localparam int GAIN_SH = 8;
  localparam int DUTY_SH = 15;
  // resistance code breakpoints (raw code values; decoded results are in milliohm)
  localparam logic [7:0] RC_A = 8'h10;
  localparam logic [7:0] RC_B = 8'h40;
  localparam logic [7:0] RC_C = 8'h88;
  localparam logic [7:0] RC_D = 8'h9C;
  localparam logic [7:0] RC_E = 8'hAB;
  localparam logic [7:0] RC_F = 8'hC0;
  localparam logic [7:0] RC_G = 8'hCA;
  localparam logic [7:0] RC_SELF = 8'h00;

  // loop sequencing states
  typedef enum logic [2:0] {
    ST_IDLE, ST_MEAS, ST_WAIT, ST_RAMP, ST_SPEED, ST_DAX, ST_QAX
  } loop_state_t;

  // observer and current feedback bundle
  typedef struct packed {
    logic signed [DW-1:0] theta;
    logic signed [DW-1:0] speed;
    logic signed [DW-1:0] id;
    logic signed [DW-1:0] iq;
  } feedback_t;
endpackage

/* File: hdl/foc_closed_loop_control.sv */
`timescale 1ns/1ps
// Function
// RULE_01: d-axis current reference held at zero
// RULE_02: loops use observer angle and speed
// RULE_03: ramped reference slews linearly to target
// RULE_04: fall rate ignored while surge guard active
// RULE_05: speed PI on ramp minus estimate
// RULE_06: speed output clamped to current ceiling
// RULE_07: speed integrator frozen when saturated
// RULE_08: d and q PI share gains
// RULE_09: voltage commands clamped to supply limit
// RULE_10: d-axis loop runs before q-axis loop
// RULE_11: current integrator frozen when saturated
// RULE_12: bypass makes iq reference duty times ceiling
// RULE_13: host selects hi-z stop in torque mode
// RULE_14: overmodulation flag drives modulator option
// RULE_15: measurement completes before run, else stored
// RULE_16: resistance code zero selects measured value
// RULE_17: nonzero codes decode via nonlinear table
// RULE_18: host programs nearest resistance code
// RULE_19: one update per pwm period, reset clears
// RULE_20: ramp step bounded, no overshoot
module foc_closed_loop_control #(
  parameter int W = foc_pkg::DW
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  pwm_tick,
  input  wire foc_pkg::feedback_t    fb,
  input  wire logic                  surge_guard,
  input  wire logic                  meas_done,
  input  wire logic [15:0]           meas_res,
  output logic                       meas_start,
  output logic signed [15:0]         vd_cmd,
  output logic signed [15:0]         vq_cmd,
  output logic signed [15:0]         theta_cmd,
  output logic                       overmod_en,
  output logic [2:0]                 stop_method,
  output logic [15:0]                res_mohm
);
  import foc_pkg::*;

  // width is fixed by the 16-bit field layout
  if (W != DW) begin : g_chk
    $error("W must equal 16");
  end

  logic [31:0]          ctrl_reg;     // run, bypass, overmod, measure, stop
  logic [31:0]          rate_reg;     // rise low, fall high
  logic [31:0]          vgain_reg;    // velocity kp low, ki high
  logic [31:0]          cgain_reg;    // current kp low, ki high
  logic [31:0]          limit_reg;    // ceiling low, supply clamp high
  logic [31:0]          target_reg;   // speed target low, duty high
  logic [7:0]           rescode_reg;  // phase resistance code
  loop_state_t          state_reg;    // loop sequencer
  logic signed [15:0]   ramp_reg;     // ramped speed reference
  logic signed [15:0]   iqref_reg;    // q-axis current reference
  logic signed [31:0]   sint_reg;     // speed integrator
  logic signed [31:0]   dint_reg;     // d-axis integrator
  logic signed [31:0]   qint_reg;     // q-axis integrator
  logic                 dsat_reg;     // d output saturated this step
  logic                 qsat_reg;     // q output saturated this step
  logic                 ssat_reg;     // speed output saturated
  logic                 ready_reg;    // parameters resolved

  // limits are forced positive on write, so negating them never overflows
  wire logic signed [15:0] ceil_s = signed'(limit_reg[15:0]);
  wire logic signed [15:0] vmax_s = signed'(limit_reg[31:16]);

  // clamp a wide value to +/- lim
  function automatic logic signed [15:0] clamp(input logic signed [31:0] x,
                                               input logic signed [15:0] lim);
    logic signed [31:0] l;
    l = 32'(lim);
    // widened limit compares against the full sum
    if (x > l) clamp = lim;
    else if (x < -l) clamp = -lim;
    else clamp = x[15:0];
  endfunction

  // true when a wide value exceeds +/- lim
  function automatic logic over(input logic signed [31:0] x,
                                input logic signed [15:0] lim);
    logic signed [31:0] l;
    l = 32'(lim);
    over = (x > l) || (x < -l);
  endfunction

  // scaled product of gain and error
  function automatic logic signed [31:0] gmul(input logic [15:0] g,
                                              input logic signed [31:0] e);
    logic signed [47:0] p;
    // 48 bits hold any 16-bit gain times a 32-bit error
    p = $signed({32'h0000_0000, g}) * 48'(e);
    gmul = p[GAIN_SH+31:GAIN_SH];
  endfunction

  // nonlinear resistance table; step widens with code range
  function automatic logic [15:0] res_decode(input logic [7:0] c);
    logic [15:0] k;
    // each segment starts above the last value of the previous segment
    // codes between listed rows are interpolated on the same step
    k = {8'h00, c};
    if (c < RC_A) res_decode = 16'h0005 + k;
    else if (c < RC_B) res_decode = 16'h0016 + 16'((k - 16'h0010) * 2);
    else if (c < RC_C) res_decode = 16'h0091 + 16'((k - 16'h0040) * 5);
    else if (c < RC_D) res_decode = 16'h01FE + 16'((k - 16'h0088) * 10);
    else if (c < RC_E) res_decode = 16'h02D0 + 16'((k - 16'h009C) * 20);
    else if (c < RC_F) res_decode = 16'h03E8 + 16'((k - 16'h00AA) * 50);
    else if (c < RC_G) res_decode = 16'h0834 + 16'((k - 16'h00C0) * 100);
    else res_decode = 16'h0C80 + 16'((k - 16'h00CA) * 200);
  endfunction

  // apb access phase; one wait state so read data comes from a flop
  // if the master keeps penable high, the access is answered again every second cycle
  wire logic acc = psel && penable;
  wire logic wr_go = acc && pready && pwrite;
  wire logic mapped = (paddr <= STAT_OFF) && (paddr[1:0] == 2'b00);

  // handshake and read data
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      // zero outside the answer cycle, so no stale word shows
      prdata  <= 32'h0000_0000;
      if (acc && !pready && !pwrite) begin
        case (paddr)
          CTRL_OFF:   prdata <= ctrl_reg;
          RATE_OFF:   prdata <= rate_reg;
          VGAIN_OFF:  prdata <= vgain_reg;
          CGAIN_OFF:  prdata <= cgain_reg;
          LIMIT_OFF:  prdata <= limit_reg;
          TARGET_OFF: prdata <= target_reg;
          RES_OFF:    prdata <= {24'h000000, rescode_reg};
          REF_OFF:    prdata <= {iqref_reg, ramp_reg};
          VOLT_OFF:   prdata <= {vq_cmd, vd_cmd};
          STAT_OFF:   prdata <= {8'h00, 5'h00, 3'(state_reg), res_mohm};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration writes; status registers ignore writes
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg    <= CTRL_RST;
      rate_reg    <= RATE_RST;
      vgain_reg   <= GAIN_RST;
      cgain_reg   <= GAIN_RST;
      limit_reg   <= LIMIT_RST;
      target_reg  <= 32'h0000_0000;
      rescode_reg <= 8'h00;
    end else if (wr_go) begin
      case (paddr)
        // bits above the stop field are reserved and read back as zero
        CTRL_OFF:   ctrl_reg    <= {25'h0000000, pwdata[6:0]};
        RATE_OFF:   rate_reg    <= pwdata;
        VGAIN_OFF:  vgain_reg   <= pwdata;
        CGAIN_OFF:  cgain_reg   <= pwdata;
        // sign bits kept clear so both limits stay positive
        LIMIT_OFF:  limit_reg   <= {1'b0, pwdata[30:16], 1'b0, pwdata[14:0]};
        TARGET_OFF: target_reg  <= pwdata;
        RES_OFF:    rescode_reg <= pwdata[7:0];
        default:    ;
      endcase
    end
  end

  // sequencer: measure first if asked, then one pass per pwm tick
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg  <= ST_IDLE;
      ready_reg  <= 1'b0;
      meas_start <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      case (state_reg)
        // measurement runs once per reset; later runs reuse the result
        ST_IDLE: if (ctrl_reg[CTRL_RUN]) begin
          if (ctrl_reg[CTRL_MEAS] && !ready_reg) begin // RULE_15
            meas_start <= 1'b1;
            state_reg  <= ST_MEAS;
          end else begin
            ready_reg <= 1'b1;
            state_reg <= ST_WAIT;
          end
        end
        // no timeout here: the measuring engine sets the pace
        ST_MEAS: if (meas_done) begin // RULE_15
          ready_reg <= 1'b1;
          state_reg <= ST_WAIT;
        end
        // a pass in flight always finishes before run is dropped
        ST_WAIT: begin
          if (!ctrl_reg[CTRL_RUN]) state_reg <= ST_IDLE;
          else if (pwm_tick) state_reg <= ST_RAMP; // RULE_19
        end
        ST_RAMP:  state_reg <= ST_SPEED;
        ST_SPEED: state_reg <= ST_DAX;
        ST_DAX:   state_reg <= ST_QAX; // RULE_10
        ST_QAX:   state_reg <= ST_WAIT;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // speed ramp: bounded step, lands on the target exactly
  wire logic signed [15:0] tgt = signed'(target_reg[15:0]);
  // one bit wider than the reference so a full swing cannot wrap
  wire logic signed [16:0] gap = 17'(tgt) - 17'(ramp_reg);
  wire logic signed [16:0] up  = 17'({1'b0, rate_reg[15:0]});
  wire logic signed [16:0] dn  = 17'({1'b0, rate_reg[31:16]});
  always_ff @(posedge mclk) begin
    if (reset || state_reg == ST_IDLE) begin
      ramp_reg <= 16'h0000;
    end else if (state_reg == ST_RAMP) begin
      // the last step lands on the target, never past it
      if (gap > 0) // RULE_03
        ramp_reg <= (gap > up) ? 16'(17'(ramp_reg) + up) : tgt; // RULE_20
      else if (gap < 0 && surge_guard) // RULE_04
        ramp_reg <= ramp_reg; // surge guard owns braking, hold the reference
      else if (gap < 0)
        ramp_reg <= (-gap > dn) ? 16'(17'(ramp_reg) - dn) : tgt; // RULE_20
    end
  end

  // speed loop or torque bypass
  wire logic signed [31:0] serr  = 32'(ramp_reg) - 32'(fb.speed); // RULE_02
  // saturation is judged on the full sum, before the clamp
  wire logic signed [31:0] sint1 = sint_reg + gmul(vgain_reg[31:16], serr);
  wire logic signed [31:0] sout  = gmul(vgain_reg[15:0], serr) + sint1; // RULE_05
  // duty is signed Q15; the product is shifted back by its fraction bits
  wire logic signed [31:0] duty_x = 32'(signed'(target_reg[31:16])) * 32'(ceil_s);
  always_ff @(posedge mclk) begin
    if (reset || state_reg == ST_IDLE) begin
      iqref_reg <= 16'h0000;
      sint_reg  <= 32'h0000_0000;
      ssat_reg  <= 1'b0;
    end else if (state_reg == ST_SPEED) begin
      if (ctrl_reg[CTRL_BYPASS]) begin
        // integrator left as is, so the loop resumes where it stopped
        iqref_reg <= clamp(duty_x >>> DUTY_SH, ceil_s); // RULE_12
        ssat_reg  <= 1'b0;
      end else begin
        iqref_reg <= clamp(sout, ceil_s); // RULE_06
        ssat_reg  <= over(sout, ceil_s);
        if (!over(sout, ceil_s)) sint_reg <= sint1; // RULE_07
      end
    end
  end

  // current loops share one gain pair; d reference is zero
  // d runs one cycle ahead of q so its saturation is known first
  wire logic signed [31:0] derr  = 32'h0000_0000 - 32'(fb.id); // RULE_01
  wire logic signed [31:0] qerr  = 32'(iqref_reg) - 32'(fb.iq);
  wire logic signed [31:0] dint1 = dint_reg + gmul(cgain_reg[31:16], derr); // RULE_08
  wire logic signed [31:0] qint1 = qint_reg + gmul(cgain_reg[31:16], qerr); // RULE_08
  wire logic signed [31:0] dout  = gmul(cgain_reg[15:0], derr) + dint1;
  wire logic signed [31:0] qout  = gmul(cgain_reg[15:0], qerr) + qint1;
  always_ff @(posedge mclk) begin
    if (reset || state_reg == ST_IDLE) begin
      // leaving run drops the drive to zero at once
      vd_cmd   <= 16'h0000;
      vq_cmd   <= 16'h0000;
      dint_reg <= 32'h0000_0000;
      qint_reg <= 32'h0000_0000;
      dsat_reg <= 1'b0;
      qsat_reg <= 1'b0;
    end else if (state_reg == ST_DAX) begin
      vd_cmd   <= clamp(dout, vmax_s); // RULE_09
      dsat_reg <= over(dout, vmax_s); // RULE_10
      if (!over(dout, vmax_s)) dint_reg <= dint1; // RULE_11
    end else if (state_reg == ST_QAX) begin
      vq_cmd   <= clamp(qout, vmax_s); // RULE_09
      qsat_reg <= over(qout, vmax_s);
      if (!over(qout, vmax_s)) qint_reg <= qint1; // RULE_11
    end
  end

  // angle, options and resistance source
  always_ff @(posedge mclk) begin
    if (reset) begin
      theta_cmd   <= 16'h0000;
      overmod_en  <= 1'b0;
      stop_method <= 3'b000;
      res_mohm    <= 16'h0000;
    end else begin
      // angle taken with the q step so it matches the voltages
      if (state_reg == ST_QAX) theta_cmd <= fb.theta; // RULE_02
      // options follow the control word one cycle late
      overmod_en  <= ctrl_reg[CTRL_OVMOD]; // RULE_14
      stop_method <= ctrl_reg[CTRL_STOP+2:CTRL_STOP];
      // measured value only once ready_reg is set, with or without a measurement
      if (rescode_reg == RC_SELF) res_mohm <= ready_reg ? meas_res : 16'h0000; // RULE_16
      else res_mohm <= res_decode(rescode_reg); // RULE_17
    end
  end

  // checks on the loops
  // all checks run on the control clock and stay quiet in reset
  a_ramp_step: assert property (@(posedge mclk) disable iff (reset) // RULE_20
    (state_reg == ST_RAMP && gap > up) |=> ramp_reg == 16'($past(ramp_reg) + $past(up)))
    else $error("ramp rise step wrong");
  a_ramp_land: assert property (@(posedge mclk) disable iff (reset) // RULE_03
    (state_reg == ST_RAMP && gap > 0 && gap <= up) |=> ramp_reg == $past(tgt))
    else $error("ramp did not land on target");
  a_surge_hold: assert property (@(posedge mclk) disable iff (reset) // RULE_04
    (state_reg == ST_RAMP && gap < 0 && surge_guard) |=> $stable(ramp_reg))
    else $error("fall rate used under surge guard");
  a_iq_limit: assert property (@(posedge mclk) disable iff (reset) // RULE_06
    state_reg == ST_SPEED |=> iqref_reg <= $past(ceil_s) && iqref_reg >= -$past(ceil_s))
    else $error("iq reference beyond ceiling");
  a_sint_freeze: assert property (@(posedge mclk) disable iff (reset) // RULE_07
    (state_reg == ST_SPEED && !ctrl_reg[CTRL_BYPASS] && over(sout, ceil_s))
      |=> $stable(sint_reg) && ssat_reg)
    else $error("speed integrator wound up");
  a_loop_order: assert property (@(posedge mclk) disable iff (reset) // RULE_10
    state_reg == ST_DAX |=> state_reg == ST_QAX ##1 state_reg == ST_WAIT)
    else $error("d loop not before q loop");
  a_volt_clamp: assert property (@(posedge mclk) disable iff (reset) // RULE_09
    (state_reg == ST_QAX) |=> vq_cmd <= $past(vmax_s) && vq_cmd >= -$past(vmax_s))
    else $error("vq beyond supply clamp");
  a_dint_freeze: assert property (@(posedge mclk) disable iff (reset) // RULE_11
    (state_reg == ST_DAX && over(dout, vmax_s)) |=> $stable(dint_reg) && dsat_reg)
    else $error("d integrator wound up");
  a_qint_freeze: assert property (@(posedge mclk) disable iff (reset) // RULE_11
    (state_reg == ST_QAX && over(qout, vmax_s)) |=> $stable(qint_reg) && qsat_reg)
    else $error("q integrator wound up");
  a_meas_first: assert property (@(posedge mclk) disable iff (reset) // RULE_15
    (state_reg == ST_MEAS && !meas_done) |=> state_reg == ST_MEAS)
    else $error("run began before measurement");
  a_res_decode: assert property (@(posedge mclk) disable iff (reset) // RULE_17
    (rescode_reg == 8'h40 && $stable(rescode_reg)) |=> res_mohm == 16'h0091)
    else $error("resistance decode wrong");
endmodule

/* File: sim/motor_stage_model.sv */
`timescale 1ns/1ps
// crude plant plus observer: state moves once per control period only
module motor_stage_model #(
  parameter int          MEAS_DLY = 20,
  parameter logic [15:0] RES_MEAS = 16'h04D2
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               pwm_tick,
  input  wire logic signed [15:0] vd_cmd,
  input  wire logic signed [15:0] vq_cmd,
  input  wire logic               meas_start,
  input  wire logic signed [15:0] id_bias,
  output foc_pkg::feedback_t      fb,
  output logic                    meas_done,
  output logic [15:0]             meas_res
);
  import foc_pkg::*;
  int meas_cnt;  // cycles since the measurement request

  // currents follow voltage, speed follows iq, angle integrates speed
  always_ff @(posedge mclk) begin
    if (reset) begin
      fb <= '0;
    end else if (pwm_tick) begin
      fb.id    <= id_bias + (vd_cmd >>> 3);  // bias lets a scenario push id off zero
      fb.iq    <= vq_cmd >>> 2;
      fb.speed <= fb.speed + (fb.iq >>> 4) - (fb.speed >>> 4);
      fb.theta <= fb.theta + fb.speed + 16'sh0101;
    end
  end

  // offline measurement takes a while, then stays finished
  always_ff @(posedge mclk) begin
    if (reset) begin
      meas_cnt  <= 0;
      meas_done <= 1'b0;
    end else if (meas_start) begin
      meas_cnt <= 1;
    end else if (meas_cnt == MEAS_DLY) begin
      meas_done <= 1'b1;
    end else if (meas_cnt != 0) begin
      meas_cnt <= meas_cnt + 1;
    end
  end

  // result is not valid until done, so show garbage before that
  assign meas_res = meas_done ? RES_MEAS : ~RES_MEAS;
endmodule

/* File: sim/foc_closed_loop_control_bench.sv */
`timescale 1ns/1ps
module foc_closed_loop_control_bench;
  import foc_pkg::*;
  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               pwm_tick = 1'b0;
  logic               surge_guard = 1'b0;
  logic signed [15:0] id_bias = 16'sh0000;
  feedback_t          fb;
  logic               meas_done;
  logic [15:0]        meas_res;
  logic               meas_start;
  logic signed [15:0] vd_cmd, vq_cmd, theta_cmd;
  logic               overmod_en;
  logic [2:0]         stop_method;
  logic [15:0]        res_mohm;
  logic [31:0]        last_rd;     // word of the latest read
  logic               last_err;    // error flag of the latest access
  int                 bad_count = 0;
  int                 n_checks = 0;
  int                 starts = 0;  // measurement requests seen
  int                 cycles = 0;  // hang guard

  foc_closed_loop_control dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_tick(pwm_tick),
    .fb(fb), .surge_guard(surge_guard), .meas_done(meas_done), .meas_res(meas_res), .meas_start(meas_start),
    .vd_cmd(vd_cmd), .vq_cmd(vq_cmd), .theta_cmd(theta_cmd), .overmod_en(overmod_en),
    .stop_method(stop_method), .res_mohm(res_mohm));
  motor_stage_model plant (.mclk(mclk), .reset(reset), .pwm_tick(pwm_tick), .vd_cmd(vd_cmd), .vq_cmd(vq_cmd),
    .meas_start(meas_start), .id_bias(id_bias), .fb(fb), .meas_done(meas_done), .meas_res(meas_res));

  always #5 mclk = ~mclk;

  // count requests and cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (meas_start === 1'b1) begin
      starts <= starts + 1;
    end
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_ok(input logic c);
    n_checks++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: relation does not hold", $time);
    end
  endtask

  // one apb access, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(last_rd & m, exp);
  endtask

  // one control period; pass lands well before the next tick
  task automatic tick;
    @(posedge mclk);
    pwm_tick <= 1'b1;
    @(posedge mclk);
    pwm_tick <= 1'b0;
    repeat (7) @(posedge mclk);
    chk({16'h0, theta_cmd}, {16'h0, fb.theta});
  endtask

  task automatic t_regs;
    logic [7:0]  ad [5] = '{CTRL_OFF, RATE_OFF, VGAIN_OFF, CGAIN_OFF, LIMIT_OFF};
    logic [31:0] ex [5] = '{CTRL_RST, RATE_RST, GAIN_RST, GAIN_RST, LIMIT_RST};
    for (int i = 0; i < 5; i++) begin
      rdchk(ad[i], 32'hFFFF_FFFF, ex[i]);
    end
    foreach (ad[i]) begin
      apb(1'b0, VOLT_OFF + 8'(i), 32'h0);  // aligned, three unaligned, aligned
      chk({31'h0, last_err}, (i == 0 || i == 4) ? 32'h0 : 32'h1);
    end
    apb(1'b0, 8'h28, 32'h0);  // past the map: error and zero data
    chk({31'h0, last_err}, 32'h1);
    chk(last_rd, 32'h0);
    wr(REF_OFF, 32'hFFFF_FFFF);  // read-only place ignores writes
    rdchk(REF_OFF, 32'hFFFF_FFFF, 32'h0);
    wr(LIMIT_OFF, 32'hFFFF_FFFF);
    rdchk(LIMIT_OFF, 32'hFFFF_FFFF, 32'h7FFF_7FFF);
  endtask

  task automatic t_meas;
    wr(RES_OFF, 32'h0);
    wr(CTRL_OFF, 32'h0000_0009);
    repeat (3) @(posedge mclk);
    chk(starts, 1);
    chk({16'h0, res_mohm}, 32'h0);
    for (int i = 0; i < 30 && last_rd[18:16] !== 3'd2; i++) begin
      apb(1'b0, STAT_OFF, 32'h0);
    end
    chk({29'h0, last_rd[18:16]}, 32'h2);
    chk({16'h0, res_mohm}, 32'h0000_04D2);
    wr(CTRL_OFF, 32'h0);
    wr(CTRL_OFF, 32'h0000_0009);
    repeat (30) @(posedge mclk);
    chk(starts, 1);
  endtask

  task automatic t_decode;
    logic [7:0]  cd [10] = '{8'h01, 8'h10, 8'h40, 8'h87, 8'h88, 8'h9C, 8'hAA, 8'hAB, 8'hC9, 8'hE7};
    logic [15:0] mo [10] = '{16'd6, 16'd22, 16'd145, 16'd500, 16'd510, 16'd720, 16'd1000, 16'd1050, 16'd3000,
                             16'd9000};
    foreach (cd[i]) begin
      wr(RES_OFF, {24'h0, cd[i]});
      repeat (2) @(posedge mclk);
      chk({16'h0, res_mohm}, {16'h0, mo[i]});
    end
  endtask

  // rise to a target that is not a multiple of the step, then fall
  task automatic t_ramp;
    logic [15:0] st [9] = '{16'd16, 16'd32, 16'd48, 16'd53, 16'd37, 16'd37, 16'd21, 16'd20, 16'd20};
    wr(TARGET_OFF, 32'h0000_0035);
    foreach (st[i]) begin
      if (i == 4) begin
        wr(TARGET_OFF, 32'h0000_0014);
      end
      surge_guard <= (i == 5);
      tick();
      rdchk(REF_OFF, 32'h0000_FFFF, {16'h0, st[i]});
      if (i < 3) begin
        chk_ok($signed(last_rd[31:16]) > 0);
      end
    end
  endtask

  // tight ceiling and supply clamp with a large error on both axes
  task automatic t_sat;
    wr(LIMIT_OFF, 32'h0010_0040);
    wr(RATE_OFF, 32'h0010_1000);
    wr(TARGET_OFF, 32'h0000_4000);
    id_bias <= 16'sh0200;
    repeat (4) tick();
    rdchk(REF_OFF, 32'hFFFF_0000, 32'h0040_0000);
    chk({16'h0, vd_cmd}, 32'h0000_FFF0);
    chk({16'h0, vq_cmd}, 32'h0000_0010);
  endtask

  task automatic t_bypass;
    logic [15:0] dt [3] = '{16'h4000, 16'hC000, 16'h7FFF};
    logic [15:0] iq [3] = '{16'h0020, 16'hFFE0, 16'h003F};
    wr(CTRL_OFF, 32'h0000_0007);
    repeat (2) @(posedge mclk);
    chk({31'h0, overmod_en}, 32'h1);
    chk({29'h0, stop_method}, 32'h0);
    foreach (dt[i]) begin
      wr(TARGET_OFF, {dt[i], 16'h0});
      tick();
      rdchk(REF_OFF, 32'hFFFF_0000, {iq[i], 16'h0});
    end
    wr(CTRL_OFF, 32'h0000_0051);
    repeat (2) @(posedge mclk);
    chk({31'h0, overmod_en}, 32'h0);
    chk({29'h0, stop_method}, 32'h5);
    wr(CTRL_OFF, 32'h0);
    repeat (3) @(posedge mclk);
    chk({vd_cmd, vq_cmd}, 32'h0);
    rdchk(REF_OFF, 32'hFFFF_FFFF, 32'h0);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_meas();
    t_decode();
    t_ramp();
    t_sat();
    t_bypass();
    complete_run();
  end
endmodule
